// file: pkg/tdm_timing_regs.vh
/*
  Register offsets, field positions, reset values and timing constants of the
  TDM system-side timing block.
  Assumes a 32-bit APB slave with byte addresses and a 200 MHz core clock.
*/
`ifndef TDM_TIMING_REGS_VH
`define TDM_TIMING_REGS_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define TDM_ADDR_GLOBAL 12'h010
`define TDM_ADDR_FP_LINK1 12'h048
`define TDM_ADDR_FP_LINK2 12'h148
`define TDM_ADDR_CTRL_LINK1 12'h0a0
`define TDM_ADDR_CTRL_LINK2 12'h1a0
`define TDM_ADDR_STATUS 12'h0f0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TDM_GLB_RX_MUX 0
`define TDM_GLB_TX_SHARED 1
`define TDM_GLB_TX_MUX 2
`define TDM_GLB_MUX_DOUBLE 3
`define TDM_GLB_RX_SHARED 4
`define TDM_FP_INVERT 4
`define TDM_CTL_MASTER 0
`define TDM_CTL_E1 1
`define TDM_CTL_FPSEL_LO 2
`define TDM_CTL_DOUBLE 5
`define TDM_CTL_ESF 6
`define TDM_GLB_RESET 5'h00
`define TDM_CTL_RESET 7'h00

// ----------------------------------------------------------------
// Frame structure and clock synthesis
// ----------------------------------------------------------------
`define TDM_T1_LAST_BIT 9'd192
`define TDM_E1_LAST_BIT 9'd255
`define TDM_SF_LAST_FRAME 5'd11
`define TDM_ESF_LAST_FRAME 5'd23
`define TDM_E1_LAST_FRAME 5'd15
`define TDM_TS_OVH_A 5'd1
`define TDM_TS_OVH_B 5'd16
`define TDM_CORE_HZ 200000000
`define TDM_T1_HZ 1544000
`define TDM_E1_HZ 2048000
`define TDM_NCO_T1 32'h01f9ed6b
`define TDM_NCO_E1 32'h029f16b1

`endif

// file: src/tdm_sys_timing.v
/*
  System-side TDM timing for two T1/J1/E1 links: per-link receive clock and
  frame pulse (master or slave), receive data and signaling serialisers,
  transmit data sampling, and the byte-interleaved multiplexed buses.
  Assumes all system pins are asynchronous to core_clk and at least four
  times slower; the core side supplies receive bytes and takes transmit bytes.
*/
`timescale 1ns/1ps
`include "tdm_timing_regs.vh"

module tdm_sys_timing (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Per-link receive system pins
  input wire [1:0] rxSystemClockIn,
  output wire [1:0] rxSystemClockOut,
  output wire [1:0] rxSystemClockOe,
  input wire [1:0] rxFramePulseIn,
  output wire [1:0] rxFramePulseOut,
  output wire [1:0] rxFramePulseOe,
  output wire [1:0] rxSystemData,
  output wire [1:0] rxSystemSignaling,
  // Per-link transmit system pins
  input wire [1:0] txSystemClock,
  input wire [1:0] txSystemData,
  // Multiplexed receive pins
  input wire muxRxSystemClock,
  input wire muxRxFramePulse,
  output wire muxRxSystemData,
  output wire muxRxSystemSignaling,
  // Multiplexed transmit pins
  input wire muxTxSystemClock,
  input wire muxTxSystemData,
  input wire muxTxFramePulse,
  // Core side
  input wire [15:0] rxLineByte,
  input wire [7:0] rxLineSig,
  output wire [9:0] rxTimeslot,
  output wire [5:0] muxRxSlot,
  output wire [15:0] txLineByte,
  output wire [1:0] txLineStb,
  output wire [7:0] muxTxLineByte,
  output wire muxTxLineLink,
  output wire muxTxLineStb
);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  reg [4:0] glb_q;
  reg [1:0] fpInv_q;
  reg [13:0] linkCtrl_q;
  reg [31:0] prdata_q;
  reg pready_q;
  reg pslverr_q;
  reg [31:0] rdMux;
  reg rdHit;
  wire [9:0] frameCntAll;
  wire rxMux = glb_q[`TDM_GLB_RX_MUX];
  wire txMux = glb_q[`TDM_GLB_TX_MUX];
  wire rxSharedSlaveClockSelect = glb_q[`TDM_GLB_RX_SHARED];
  wire txSharedSlaveClockSelect = glb_q[`TDM_GLB_TX_SHARED];
  wire apbWrite = psel & penable & pready_q & pwrite;

  always @* begin
    rdHit = 1'b1;
    rdMux = 32'h0;
    if (paddr == `TDM_ADDR_GLOBAL) begin
      rdMux = {27'h0, glb_q};
    end else if (paddr == `TDM_ADDR_FP_LINK1) begin
      rdMux = {27'h0, fpInv_q[0], 4'h0};
    end else if (paddr == `TDM_ADDR_FP_LINK2) begin
      rdMux = {27'h0, fpInv_q[1], 4'h0};
    end else if (paddr == `TDM_ADDR_CTRL_LINK1) begin
      rdMux = {25'h0, linkCtrl_q[6:0]};
    end else if (paddr == `TDM_ADDR_CTRL_LINK2) begin
      rdMux = {25'h0, linkCtrl_q[13:7]};
    end else if (paddr == `TDM_ADDR_STATUS) begin
      rdMux = {6'h0, frameCntAll, txLineByte};
    end else begin
      rdHit = 1'b0;
    end
  end

  // No wait state: the answer is prepared during the setup cycle
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      glb_q <= `TDM_GLB_RESET;
      fpInv_q <= 2'h0;
      linkCtrl_q <= {`TDM_CTL_RESET, `TDM_CTL_RESET};
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= psel & ~penable;
      if (psel & ~penable) begin
        prdata_q <= pwrite ? 32'h0 : rdMux;
        pslverr_q <= ~rdHit;
      end
      if (apbWrite) begin
        if (paddr == `TDM_ADDR_GLOBAL) begin
          glb_q <= pwdata[4:0];
        end else if (paddr == `TDM_ADDR_FP_LINK1) begin
          fpInv_q[0] <= pwdata[`TDM_FP_INVERT];
        end else if (paddr == `TDM_ADDR_FP_LINK2) begin
          fpInv_q[1] <= pwdata[`TDM_FP_INVERT];
        end else if (paddr == `TDM_ADDR_CTRL_LINK1) begin
          linkCtrl_q[6:0] <= pwdata[6:0];
        end else if (paddr == `TDM_ADDR_CTRL_LINK2) begin
          linkCtrl_q[13:7] <= pwdata[6:0];
        end
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------------------------------
  // Per-link receive and transmit timing
  // ----------------------------------------------------------------
  wire [1:0] rxClkNow;
  wire [1:0] rxClkOld;
  wire [1:0] txClkNow;
  wire [1:0] txClkOld;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : link
      reg clkS1_q, clkS2_q, clkS3_q, fpS1_q, fpS2_q;
      reg txcS1_q, txcS2_q, txcS3_q, txdS1_q, txdS2_q;
      reg [31:0] nco_q;
      reg clkOut_q, oe_q, fpOut_q, data_q, sig_q, dblPh_q;
      reg [8:0] bitCnt_q;
      reg [4:0] frameCnt_q, slot_q;
      reg [7:0] sh_q, sigSh_q, txSh_q, txByte_q;
      reg [2:0] txCnt_q;
      reg txStb_q;
      wire [6:0] ctl = linkCtrl_q[g*7 +: 7];
      wire master = ctl[`TDM_CTL_MASTER] & ~rxMux;
      wire e1 = ctl[`TDM_CTL_E1];
      wire [2:0] fpSel = ctl[`TDM_CTL_FPSEL_LO +: 3];
      wire inv = fpInv_q[g];
      wire rxSrc = rxSharedSlaveClockSelect ? 1'b0 : (g == 1);
      wire slaveEdge = rxClkNow[rxSrc] & ~rxClkOld[rxSrc];
      // 4.096 MHz slave clock carries two edges per bit
      wire slaveTick = slaveEdge & (~ctl[`TDM_CTL_DOUBLE] | dblPh_q);
      wire [31:0] ncoNext = nco_q + (e1 ? `TDM_NCO_E1 : `TDM_NCO_T1);
      wire ncoRise = ~nco_q[31] & ncoNext[31];
      wire tick = master ? ncoRise : (slaveTick & ~rxMux);
      wire fpActive = fpS2_q ^ inv;
      wire [8:0] curBit = (~master & fpActive) ? 9'd0 : bitCnt_q;
      wire [8:0] lastBit = e1 ? `TDM_E1_LAST_BIT : `TDM_T1_LAST_BIT;
      wire [4:0] lastFrame = e1 ? `TDM_E1_LAST_FRAME :
        ((ctl[`TDM_CTL_ESF] | fpSel == 3'd3) ? `TDM_ESF_LAST_FRAME : `TDM_SF_LAST_FRAME);
      wire [8:0] dataBit = e1 ? curBit : curBit - 9'd1;
      wire isFbit = ~e1 & (curBit == 9'd0);
      wire atStart = curBit == 9'd0;
      wire mfStart = atStart & (frameCnt_q == 5'd0);
      wire ovh = (dataBit[7:3] == `TDM_TS_OVH_A) | (dataBit[7:3] == `TDM_TS_OVH_B);
      wire pulseT1 = (fpSel == 3'd0) ? atStart :
        (fpSel == 3'd1) ? (atStart & ~frameCnt_q[0]) : mfStart;
      wire pulseE1 = (fpSel == 3'd0) ? atStart :
        (fpSel == 3'd4) ? ovh : mfStart;
      wire [7:0] inByte = rxLineByte[g*8 +: 8];
      wire txSrc = txSharedSlaveClockSelect ? 1'b0 : (g == 1);
      wire txEdge = txClkNow[txSrc] & ~txClkOld[txSrc];

      assign rxClkNow[g] = clkS2_q;
      assign rxClkOld[g] = clkS3_q;
      assign txClkNow[g] = txcS2_q;
      assign txClkOld[g] = txcS3_q;

      always @(posedge core_clk or posedge rst) begin
        if (rst) begin
          // Clock pins idle high; starting high avoids a false edge after reset
          {clkS1_q, clkS2_q, clkS3_q, fpS1_q, fpS2_q} <= 5'h1c;
          {txcS1_q, txcS2_q, txcS3_q, txdS1_q, txdS2_q} <= 5'h1c;
          nco_q <= 32'h0;
          {clkOut_q, oe_q, fpOut_q, data_q, sig_q, dblPh_q} <= 6'h0;
          bitCnt_q <= 9'h0;
          frameCnt_q <= 5'h0;
          slot_q <= 5'h0;
          {sh_q, sigSh_q, txSh_q, txByte_q} <= 32'h0;
          txCnt_q <= 3'h0;
          txStb_q <= 1'b0;
        end else begin
          clkS1_q <= rxSystemClockIn[g];
          clkS2_q <= clkS1_q;
          clkS3_q <= clkS2_q;
          fpS1_q <= rxFramePulseIn[g];
          fpS2_q <= fpS1_q;
          txcS1_q <= txSystemClock[g];
          txcS2_q <= txcS1_q;
          txcS3_q <= txcS2_q;
          txdS1_q <= txSystemData[g];
          txdS2_q <= txdS1_q;
          nco_q <= master ? ncoNext : 32'h0;
          clkOut_q <= master & ncoNext[31];
          oe_q <= master;
          if (slaveEdge) begin
            dblPh_q <= ~dblPh_q;
          end
          if (~master) begin
            fpOut_q <= inv;
          end
          if (tick) begin
            bitCnt_q <= (curBit == lastBit) ? 9'd0 : curBit + 9'd1;
            if (curBit == lastBit) begin
              frameCnt_q <= (frameCnt_q >= lastFrame) ? 5'd0 : frameCnt_q + 5'd1;
            end
            if (master) begin
              fpOut_q <= (e1 ? pulseE1 : pulseT1) ^ inv;
            end
            if (isFbit) begin
              data_q <= 1'b0;
              sig_q <= 1'b0;
            end else if (dataBit[2:0] == 3'd0) begin
              data_q <= inByte[7];
              sh_q <= {inByte[6:0], 1'b0};
              sig_q <= 1'b0;
              sigSh_q <= {3'h0, rxLineSig[g*4 +: 4], 1'b0};
              slot_q <= dataBit[7:3];
            end else begin
              data_q <= sh_q[7];
              sh_q <= {sh_q[6:0], 1'b0};
              sig_q <= sigSh_q[7];
              sigSh_q <= {sigSh_q[6:0], 1'b0};
            end
          end
          txStb_q <= 1'b0;
          if (txEdge & ~txMux) begin
            txSh_q <= {txSh_q[6:0], txdS2_q};
            txCnt_q <= txCnt_q + 3'd1;
            if (txCnt_q == 3'd7) begin
              txByte_q <= {txSh_q[6:0], txdS2_q};
              txStb_q <= 1'b1;
            end
          end
        end
      end

      assign rxSystemClockOut[g] = clkOut_q;
      assign rxSystemClockOe[g] = oe_q;
      assign rxFramePulseOut[g] = fpOut_q;
      assign rxFramePulseOe[g] = oe_q;
      assign rxSystemData[g] = data_q;
      assign rxSystemSignaling[g] = sig_q;
      assign rxTimeslot[g*5 +: 5] = slot_q;
      assign frameCntAll[g*5 +: 5] = frameCnt_q;
      assign txLineByte[g*8 +: 8] = txByte_q;
      assign txLineStb[g] = txStb_q;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Multiplexed buses: 1024 bit periods per frame, link 1 byte first
  // ----------------------------------------------------------------
  reg mrcS1_q, mrcS2_q, mrcS3_q, mrfS1_q, mrfS2_q, mrPh_q;
  reg mtcS1_q, mtcS2_q, mtcS3_q, mtdS1_q, mtdS2_q, mtfS1_q, mtfS2_q, mtPh_q;
  reg [9:0] mrCnt_q, mtCnt_q;
  reg [7:0] mrSh_q, mrSigSh_q, mtSh_q, mtByte_q;
  reg mrData_q, mux_rx_system_signaling_q, mtLink_q, mtStb_q;
  reg [5:0] mrSlot_q;
  wire muxDouble = glb_q[`TDM_GLB_MUX_DOUBLE];
  wire mrEdge = mrcS2_q & ~mrcS3_q;
  wire mrTick = mrEdge & (~muxDouble | mrPh_q) & rxMux;
  wire [9:0] mrCur = (mrfS2_q ^ fpInv_q[0]) ? 10'd0 : mrCnt_q;
  wire mrLink = mrCur[3];
  wire [7:0] mrByte = mrLink ? rxLineByte[15:8] : rxLineByte[7:0];
  wire [3:0] mrNib = mrLink ? rxLineSig[7:4] : rxLineSig[3:0];
  wire mtEdge = mtcS2_q & ~mtcS3_q;
  wire mtTick = mtEdge & (~muxDouble | mtPh_q) & txMux;
  wire [9:0] mtCur = (mtfS2_q ^ fpInv_q[0]) ? 10'd0 : mtCnt_q;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {mrcS1_q, mrcS2_q, mrcS3_q, mrfS1_q, mrfS2_q, mrPh_q} <= 6'h38;
      {mtcS1_q, mtcS2_q, mtcS3_q, mtdS1_q, mtdS2_q, mtfS1_q, mtfS2_q, mtPh_q} <= 8'he0;
      mrCnt_q <= 10'h0;
      mtCnt_q <= 10'h0;
      {mrSh_q, mrSigSh_q, mtSh_q, mtByte_q} <= 32'h0;
      {mrData_q, mux_rx_system_signaling_q, mtLink_q, mtStb_q} <= 4'h0;
      mrSlot_q <= 6'h0;
    end else begin
      mrcS1_q <= muxRxSystemClock;
      mrcS2_q <= mrcS1_q;
      mrcS3_q <= mrcS2_q;
      mrfS1_q <= muxRxFramePulse;
      mrfS2_q <= mrfS1_q;
      mtcS1_q <= muxTxSystemClock;
      mtcS2_q <= mtcS1_q;
      mtcS3_q <= mtcS2_q;
      mtdS1_q <= muxTxSystemData;
      mtdS2_q <= mtdS1_q;
      mtfS1_q <= muxTxFramePulse;
      mtfS2_q <= mtfS1_q;
      if (mrEdge) begin
        mrPh_q <= ~mrPh_q;
      end
      if (mtEdge) begin
        mtPh_q <= ~mtPh_q;
      end
      if (mrTick) begin
        mrCnt_q <= mrCur + 10'd1;
        // Only the first 64 byte slots carry traffic; the rest idle low
        if (mrCur[9]) begin
          mrData_q <= 1'b0;
          mux_rx_system_signaling_q <= 1'b0;
        end else if (mrCur[2:0] == 3'd0) begin
          mrData_q <= mrByte[7];
          mrSh_q <= {mrByte[6:0], 1'b0};
          mux_rx_system_signaling_q <= 1'b0;
          mrSigSh_q <= {3'h0, mrNib, 1'b0};
          mrSlot_q <= mrCur[8:3];
        end else begin
          mrData_q <= mrSh_q[7];
          mrSh_q <= {mrSh_q[6:0], 1'b0};
          mux_rx_system_signaling_q <= mrSigSh_q[7];
          mrSigSh_q <= {mrSigSh_q[6:0], 1'b0};
        end
      end
      mtStb_q <= 1'b0;
      if (mtTick) begin
        mtCnt_q <= mtCur + 10'd1;
        mtSh_q <= {mtSh_q[6:0], mtdS2_q};
        if (mtCur[2:0] == 3'd7 && !mtCur[9]) begin
          mtByte_q <= {mtSh_q[6:0], mtdS2_q};
          mtLink_q <= mtCur[3];
          mtStb_q <= 1'b1;
        end
      end
    end
  end

  assign muxRxSystemData = mrData_q;
  assign muxRxSystemSignaling = mux_rx_system_signaling_q;
  assign muxRxSlot = mrSlot_q;
  assign muxTxLineByte = mtByte_q;
  assign muxTxLineLink = mtLink_q;
  assign muxTxLineStb = mtStb_q;

endmodule

// file: testbench/tdm_sys_partner.sv
/*
  Backplane model: slave and mux clocks, frame pulse, transmit data.
  Assumes the bench sets run, clock enables, polarity, frame length, byte.
*/
`timescale 1ns/1ps

module tdm_sys_partner (
  // Control from the bench
  input wire run,
  input wire [5:0] en,
  input wire fpInv,
  input wire [10:0] frameBits,
  input wire [7:0] txByte,
  // Clocks: rx1 rx2 tx1 tx2 mux-rx mux-tx
  output wire [5:0] clk,
  // Frame pulse and data
  output wire fp,
  output wire [1:0] txData,
  output wire muxData
);
  logic sclk = 1'b0;
  logic [15:0] cnt;
  logic [15:0] idx;
  wire gclk = run ? sclk : 1'b1;
  wire [7:0] muxByte = idx[3] ? ~txByte : txByte;

  always #80 sclk = ~sclk;
  // Values move on the falling edge so they are steady at every rise
  always @(posedge gclk or negedge run) begin
    if (!run) cnt <= 16'h0000;
    else cnt <= cnt + 16'h0001;
  end
  always @(negedge gclk or negedge run) begin
    if (!run) idx <= 16'h0000;
    else idx <= cnt;
  end
  // Stopped clocks and pulses float high through the pin pull-ups
  assign clk = run ? ({6{sclk}} | ~en) : 6'h3f;
  assign fp = run ? ((idx % frameBits) == 16'h0000) ^ fpInv : 1'b1;
  assign txData = run ? {2{txByte[~idx[2:0]]}} : 2'h3;
  assign muxData = run ? muxByte[~idx[2:0]] : 1'b1;
endmodule

// file: testbench/tdm_sys_timing_monitor.sv
/*
  Checker of tdm_sys_timing port behaviour, bound to every instance.
  Assumes a single core_clk domain and active-high asynchronous rst.
*/
`timescale 1ns/1ps
`include "tdm_timing_regs.vh"

module tdm_sys_timing_monitor (
  // Clock, reset and APB
  input wire core_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  // Link receive
  input wire [1:0] rxSystemClockOut,
  input wire [1:0] rxSystemClockOe,
  input wire [1:0] rxFramePulseOut,
  input wire [1:0] rxFramePulseOe,
  input wire [1:0] rxSystemData,
  // Strobes and slots
  input wire [1:0] txLineStb,
  input wire muxTxLineStb,
  input wire muxTxLineLink,
  input wire [5:0] muxRxSlot
);
  // Gaps saturate so the first strobe after reset is never flagged
  logic [8:0] txGap_q;
  logic [8:0] muxGap_q;
  logic lastLink_q;
  logic muxSeen_q;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      txGap_q <= 9'h1ff;
      muxGap_q <= 9'h1ff;
      lastLink_q <= 1'b0;
      muxSeen_q <= 1'b0;
    end else begin
      txGap_q <= txLineStb[0] ? 9'h000 : txGap_q + {8'h00, txGap_q != 9'h1ff};
      muxGap_q <= muxTxLineStb ? 9'h000 : muxGap_q + {8'h00, muxGap_q != 9'h1ff};
      if (muxTxLineStb) begin
        lastLink_q <= muxTxLineLink;
        muxSeen_q <= 1'b1;
      end
    end
  end

  default clocking mcb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_inv_wr;
    psel && penable && pready && pwrite && paddr == `TDM_ADDR_FP_LINK1;
  endsequence
  property p_fp_idle;
    s_inv_wr ##2 !rxFramePulseOe[0] |-> rxFramePulseOut[0] == $past(pwdata[4], 2);
  endproperty
  a_fp_idle: assert property (p_fp_idle) else $error("pulse idle level");
  property p_fp_edge;
    rxSystemClockOe[0] && $past(rxSystemClockOe[0]) && $changed(rxFramePulseOut[0])
      |-> $rose(rxSystemClockOut[0]);
  endproperty
  a_fp_edge: assert property (p_fp_edge) else $error("pulse off clock edge");
  property p_data_edge;
    rxSystemClockOe[1] && $past(rxSystemClockOe[1]) && $changed(rxSystemData[1])
      |-> $rose(rxSystemClockOut[1]);
  endproperty
  a_data_edge: assert property (p_data_edge) else $error("data off clock edge");
  property p_fp_oe;
    rxFramePulseOe == rxSystemClockOe;
  endproperty
  a_fp_oe: assert property (p_fp_oe) else $error("pulse and clock drive differ");
  property p_tx_gap;
    txLineStb[0] |-> txGap_q >= 9'd31;
  endproperty
  a_tx_gap: assert property (p_tx_gap) else $error("tx byte too short");
  property p_mux_gap;
    muxTxLineStb |-> muxGap_q >= 9'd31;
  endproperty
  a_mux_gap: assert property (p_mux_gap) else $error("mux byte too short");
  property p_mux_alt;
    muxTxLineStb && muxSeen_q |-> muxTxLineLink != lastLink_q;
  endproperty
  a_mux_alt: assert property (p_mux_alt) else $error("mux link not alternating");
  property p_slot_pair;
    $changed(muxRxSlot) && muxRxSlot[0] |-> muxRxSlot[5:1] == $past(muxRxSlot[5:1]);
  endproperty
  a_slot_pair: assert property (p_slot_pair) else $error("link 2 slot mismatch");
endmodule

bind tdm_sys_timing tdm_sys_timing_monitor u_mon (
  .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .rxSystemClockOut(rxSystemClockOut),
  .rxSystemClockOe(rxSystemClockOe), .rxFramePulseOut(rxFramePulseOut),
  .rxFramePulseOe(rxFramePulseOe), .rxSystemData(rxSystemData), .txLineStb(txLineStb),
  .muxTxLineStb(muxTxLineStb), .muxTxLineLink(muxTxLineLink), .muxRxSlot(muxRxSlot)
);

// file: testbench/testbench.sv
/*
  Self-checking bench of tdm_sys_timing: APB tasks, backplane model, tests.
  Assumes a 160 ns backplane bit clock and a 5 ns core_clk.
*/
`timescale 1ns/1ps
`include "tdm_timing_regs.vh"

module testbench;
  logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, v, s;
  logic [15:0] rxLineByte = 16'h5aa5;
  logic [7:0] rxLineSig = 8'h99, txByte = 8'h3c;
  logic run = 1'b0, fpInv = 1'b0, err;
  logic [5:0] en = 6'h00;
  logic [10:0] frameBits = 11'd256;
  logic [4:0] t;
  logic [11:0] adr [6] = '{`TDM_ADDR_GLOBAL, `TDM_ADDR_FP_LINK1, `TDM_ADDR_FP_LINK2,
    `TDM_ADDR_CTRL_LINK1, `TDM_ADDR_CTRL_LINK2, `TDM_ADDR_STATUS};
  int num_errors = 0, checks_done = 0, n1, n2;
  wire [31:0] prdata;
  wire [15:0] txLineByte;
  wire [9:0] rxTimeslot;
  wire [7:0] muxTxLineByte;
  wire [5:0] muxRxSlot, pClk;
  wire [1:0] ckOut, ckOe, fpOut, fpOe, rxD, rxS, txLineStb, txData;
  wire pready, pslverr, fp, muxData, mrxD, mrxS, muxTxLineLink, muxTxLineStb;
  wire [4:0] watch = {pClk[4], pClk[2], pClk[0], ckOut};
  wire [3:0] sdat = {mrxS, mrxD, rxS[0], rxD[0]};
  wire [2:0] stb = {muxTxLineStb, txLineStb};

  tdm_sys_timing dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxSystemClockIn((ckOe & ckOut) | (~ckOe & pClk[1:0])),
    .rxSystemClockOut(ckOut), .rxSystemClockOe(ckOe), .rxFramePulseOut(fpOut),
    .rxFramePulseIn((fpOe & fpOut) | (~fpOe & {2{fp}})), .rxFramePulseOe(fpOe),
    .rxSystemData(rxD), .rxSystemSignaling(rxS), .txSystemClock(pClk[3:2]),
    .txSystemData(txData), .muxRxSystemClock(pClk[4]), .muxRxFramePulse(fp),
    .muxRxSystemData(mrxD), .muxRxSystemSignaling(mrxS), .muxTxSystemClock(pClk[5]),
    .muxTxSystemData(muxData), .muxTxFramePulse(fp), .rxLineByte(rxLineByte),
    .rxLineSig(rxLineSig), .rxTimeslot(rxTimeslot), .muxRxSlot(muxRxSlot),
    .txLineByte(txLineByte), .txLineStb(txLineStb), .muxTxLineByte(muxTxLineByte),
    .muxTxLineLink(muxTxLineLink), .muxTxLineStb(muxTxLineStb));
  tdm_sys_partner partner (.run(run), .en(en), .fpInv(fpInv), .frameBits(frameBits),
    .txByte(txByte), .clk(pClk), .fp(fp), .txData(txData), .muxData(muxData));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic edge_on(input int i);
    logic p;
    do begin
      p = watch[i];
      @(posedge core_clk);
    end while (!(p === 1'b0 && watch[i] === 1'b1));
  endtask
  task automatic gap(input int l, input logic inv, output int n);
    n = 0;
    do edge_on(l);
    while ((fpOut[l] ^ inv) !== 1'b1);
    do begin
      edge_on(l);
      n++;
    end while ((fpOut[l] ^ inv) !== 1'b1 && n < 600);
  endtask
  // Samples 8 cycles after the edge, well after the 2-3 cycle update latency
  task automatic grab(input int i, input int j, input int n);
    repeat (n) begin
      edge_on(i);
      repeat (8) @(posedge core_clk);
      v = {v[30:0], sdat[j]};
      s = {s[30:0], sdat[j + 1]};
    end
  endtask
  task automatic sync(input int i);
    do edge_on(i);
    while (fp !== ~fpInv);
    repeat (8) @(posedge core_clk);
  endtask
  task automatic wait_stb(input int i);
    do @(posedge core_clk);
    while (stb[i] !== 1'b1);
  endtask
  task automatic stop_test;
    $display("checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    #480000;
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    apb(1, `TDM_ADDR_STATUS, 32'hffffffff);
    foreach (adr[i]) begin
      apb(0, adr[i], 0);
      check(rd, 0);
    end
    apb(0, 12'h004, 0);
    check({err, rd[30:0]}, 32'h80000000);
    apb(1, `TDM_ADDR_GLOBAL, 32'h1f);
    apb(0, `TDM_ADDR_GLOBAL, 0);
    check(rd, 32'h1f);
    apb(1, `TDM_ADDR_GLOBAL, 0);
    $display("register test done");
    apb(1, `TDM_ADDR_FP_LINK1, 32'h10);
    repeat (3) @(posedge core_clk);
    check(fpOut[0], 1);
    apb(1, `TDM_ADDR_CTRL_LINK1, 32'h03);
    apb(1, `TDM_ADDR_CTRL_LINK2, 32'h01);
    repeat (2) @(posedge core_clk);
    check(ckOe, 2'h3);
    fork
      gap(0, 1'b1, n1);
      gap(1, 1'b0, n2);
    join
    check(n1, 256);
    check(n2, 193);
    apb(1, `TDM_ADDR_CTRL_LINK1, 32'h13);
    n1 = 0;
    repeat (256) begin
      edge_on(0);
      n1 += (fpOut[0] === 1'b0);
    end
    check(n1, 16);
    $display("master test done");
    apb(1, `TDM_ADDR_CTRL_LINK1, 32'h02);
    apb(1, `TDM_ADDR_CTRL_LINK2, 32'h02);
    apb(1, `TDM_ADDR_FP_LINK2, 32'h10);
    fpInv <= 1'b1;
    en <= 6'h01;
    run <= 1'b1;
    sync(2);
    check(rxTimeslot[4:0], 0);
    grab(2, 0, 15);
    check(v[7:0], 8'ha5);
    check(s[3:0], 4'h9);
    check(rxTimeslot[4:0], 1);
    apb(1, `TDM_ADDR_GLOBAL, 32'h10);
    t = rxTimeslot[9:5];
    repeat (600) @(posedge core_clk);
    check(t !== rxTimeslot[9:5], 1);
    run <= 1'b0;
    $display("slave test done");
    apb(1, `TDM_ADDR_GLOBAL, 0);
    en <= 6'h0c;
    run <= 1'b1;
    wait_stb(0);
    check(txLineByte[7:0], 8'h3c);
    wait_stb(1);
    check(txLineByte[15:8], 8'h3c);
    run <= 1'b0;
    apb(0, `TDM_ADDR_STATUS, 0);
    check(rd[15:0], 16'h3c3c);
    apb(1, `TDM_ADDR_GLOBAL, 32'h02);
    txByte <= 8'hc6;
    en <= 6'h04;
    run <= 1'b1;
    wait_stb(1);
    check(txLineByte[15:8], 8'hc6);
    run <= 1'b0;
    $display("transmit test done");
    apb(1, `TDM_ADDR_GLOBAL, 32'h04);
    txByte <= 8'h3c;
    frameBits <= 11'd1024;
    en <= 6'h20;
    run <= 1'b1;
    wait_stb(2);
    check({muxTxLineLink, muxTxLineByte}, 9'h03c);
    wait_stb(2);
    check({muxTxLineLink, muxTxLineByte}, 9'h1c3);
    run <= 1'b0;
    apb(1, `TDM_ADDR_GLOBAL, 32'h01);
    en <= 6'h10;
    run <= 1'b1;
    sync(4);
    check(muxRxSlot, 0);
    grab(4, 2, 31);
    check(v[15:0], 16'ha55a);
    check(muxRxSlot, 6'h03);
    $display("mux test done");
    stop_test();
  end
endmodule
